//--- design/wdt_pkg.sv
package wdt_pkg;
    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h17;
    localparam int PER_HI = 5;
    localparam int PER_LO = 4;
    localparam int ACTION_BIT = 3;
    localparam int FEED_BIT = 2;
    localparam int ENABLE_BIT = 1;
    localparam int LOCK_BIT = 0;
    localparam logic [1:0] PERIOD_RESET = 2'h3;
    localparam logic [7:0] RSVD_MASK = 8'hC0;

    // ********************************************************
    // timing
    // ********************************************************
    localparam longint CLOCK_HZ = 250000000;
    localparam longint TIMEOUT_BASE_S = 16;
    localparam longint BASE_CYCLES = TIMEOUT_BASE_S * CLOCK_HZ;
    localparam int CNT_W = 40;

    // register write request
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    // expiry outcome
    typedef struct packed {
        logic power_off;
        logic power_reset;
    } expiry_t;
endpackage

//--- design/wdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_counter
    import wdt_pkg::*;
#(
    parameter longint BASE = BASE_CYCLES
)(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic reload,
    input wire logic [1:0] period_sel,
    output logic expired
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic expired_nxt;
    logic [CNT_W-1:0] full;

    initial
    begin
        if (BASE < 1 || BASE * 8 >= (64'h1 << CNT_W))
            $error("wdt_counter: BASE out of range");
    end

    // full interval is the base shifted by the period code
    assign full = CNT_W'(BASE) << period_sel;

    // reload has priority over counting; count holds while disabled
    always_comb
    begin
        count_nxt = count_r;
        expired_nxt = 1'b0;
        if (reload)
            count_nxt = full - CNT_W'(1);
        else if (run)
        begin
            if (count_r == '0)
            begin
                expired_nxt = 1'b1;
                count_nxt = full - CNT_W'(1);
            end
            else
                count_nxt = count_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_r <= (CNT_W'(BASE) << 3) - CNT_W'(1);
            expired <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            expired <= expired_nxt;
        end
    end
endmodule
`default_nettype wire

//--- design/pmic_watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pmic_watchdog_timer
    import wdt_pkg::*;
#(
    parameter longint BASE = BASE_CYCLES,
    parameter bit ENABLE_DEFAULT = 1'b0,
    parameter bit LOCK_DEFAULT = 1'b0
)(
    input wire logic clock,
    input wire logic rst_n,
    input wire reg_wr_t wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output var expiry_t expiry
);
    // ********************************************************
    // control register
    // ********************************************************
    logic [1:0] period_r;
    logic [1:0] period_nxt;
    logic action_r;
    logic action_nxt;
    logic enable_r;
    logic enable_nxt;
    logic feed_r;
    logic feed_nxt;
    logic reload;
    logic expired;
    logic [7:0] rd_nxt;
    expiry_t expiry_nxt;
    logic hit;

    // ********************************************************
    // parameter check and address decode
    // ********************************************************
    // the 40-bit counter must hold eight base intervals
    initial
    begin
        if (BASE < 1 || BASE * 8 >= (64'h1 << CNT_W))
            $error("pmic_watchdog_timer: BASE out of range");
    end

    // one decoder shared by the write and the read path
    function automatic logic is_ctrl(input logic [7:0] a);
        return a == WATCHDOG_CONTROL_ADDR;
    endfunction

    // write strobe for the control register
    assign hit = wr.en && is_ctrl(wr.addr);

    // decode writes; bits 7:6 are not stored so they read as zero
    always_comb
    begin
        period_nxt = period_r;
        action_nxt = action_r;
        enable_nxt = enable_r;
        feed_nxt = 1'b0; // one-shot, reads 0 after the restart
        if (hit)
        begin
            period_nxt = wr.data[PER_HI:PER_LO];
            action_nxt = wr.data[ACTION_BIT];
            feed_nxt = wr.data[FEED_BIT];
            // lock blocks only the clearing direction
            if (wr.data[ENABLE_BIT] || !LOCK_DEFAULT)
                enable_nxt = wr.data[ENABLE_BIT];
        end
    end

    // reload on a feed or on any change of period
    // the counter sees period_nxt, so a period write reloads the new
    // interval at once instead of the one being replaced
    assign reload = feed_r || (hit && wr.data[PER_HI:PER_LO] != period_r);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            period_r <= PERIOD_RESET;
            action_r <= 1'b0;
            enable_r <= ENABLE_DEFAULT;
            feed_r <= 1'b0;
        end
        else
        begin
            period_r <= period_nxt;
            action_r <= action_nxt;
            enable_r <= enable_nxt;
            feed_r <= feed_nxt;
        end
    end

    // ********************************************************
    // countdown
    // ********************************************************
    wdt_counter #(
        .BASE(BASE)
    ) u_counter (
        .clock(clock),
        .rst_n(rst_n),
        .run(enable_r),
        .reload(reload),
        .period_sel(period_nxt),
        .expired(expired)
    );

    // ********************************************************
    // read-back and expiry outputs
    // ********************************************************
    // lock is a constant strap, so no write path exists
    always_comb
    begin
        rd_nxt = 8'h00;
        if (is_ctrl(rd_addr))
            rd_nxt = {2'h0, period_r, action_r, feed_r, enable_r, LOCK_DEFAULT};
        expiry_nxt.power_off = expired && !action_r;
        expiry_nxt.power_reset = expired && action_r;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rd_data <= 8'h00;
            expiry <= '0;
        end
        else
        begin
            rd_data <= rd_nxt;
            expiry <= expiry_nxt;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    AST_FEED_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
        feed_r && !(hit && wr.data[FEED_BIT]) |=> !feed_r)
        else $error("feed bit did not self clear");
    AST_FEED_ONE: assert property (@(posedge clock) disable iff (!rst_n)
        hit && wr.data[FEED_BIT] |=> feed_r)
        else $error("feed write not taken");
    AST_LOCK_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
        LOCK_DEFAULT && enable_r |=> enable_r)
        else $error("locked enable was cleared");
    AST_UNLOCK_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        !LOCK_DEFAULT && hit && !wr.data[ENABLE_BIT] |=> !enable_r)
        else $error("enable not cleared while unlocked");
    AST_SET_EN: assert property (@(posedge clock) disable iff (!rst_n)
        hit && wr.data[ENABLE_BIT] |=> enable_r)
        else $error("enable set not accepted");
    AST_PERIOD: assert property (@(posedge clock) disable iff (!rst_n)
        hit |=> period_r == $past(wr.data[PER_HI:PER_LO]))
        else $error("period not stored");
    AST_ACTION: assert property (@(posedge clock) disable iff (!rst_n)
        expired |=> expiry.power_reset == $past(action_r) && expiry.power_off != $past(action_r))
        else $error("wrong expiry action");
    AST_NO_EXP_OFF: assert property (@(posedge clock) disable iff (!rst_n)
        !enable_r ##1 !enable_r |=> !expiry.power_off && !expiry.power_reset)
        else $error("expiry while disabled");
    AST_LOCK_READ: assert property (@(posedge clock) disable iff (!rst_n)
        rd_addr == WATCHDOG_CONTROL_ADDR |=> rd_data[LOCK_BIT] == LOCK_DEFAULT)
        else $error("lock bit changed");
    AST_NOFEED: assert property (@(posedge clock) disable iff (!rst_n)
        hit && !wr.data[FEED_BIT] |=> !feed_r)
        else $error("zero feed write restarted");

    // a period change loads the newly chosen interval
    AST_PERIOD_RELOAD: assert property (@(posedge clock) disable iff (!rst_n)
        hit && wr.data[PER_HI:PER_LO] != period_r |=>
        u_counter.count_r == (CNT_W'(BASE) << $past(wr.data[PER_HI:PER_LO])) - CNT_W'(1))
        else $error("period change did not reload the new interval");

    // a feed loads the full interval of the period in force
    AST_FEED_RELOAD: assert property (@(posedge clock) disable iff (!rst_n)
        feed_r |=> u_counter.count_r == (CNT_W'(BASE) << $past(period_nxt)) - CNT_W'(1))
        else $error("feed did not reload the countdown");

    // a stopped timer keeps its count until reloaded
    AST_HOLD_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
        !enable_r && !reload |=> $stable(u_counter.count_r))
        else $error("countdown moved while disabled");

    // a running count that reaches zero expires on the next edge
    AST_EXPIRE_AT_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        enable_r && !reload && u_counter.count_r == '0 |=> expired)
        else $error("countdown reached zero without expiry");

    // the action bit is stored as written
    AST_ACTION_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        hit |=> action_r == $past(wr.data[ACTION_BIT]))
        else $error("action bit not stored");

    // reserved bits are not stored and always read back zero
    AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        is_ctrl(rd_addr) |=> (rd_data & RSVD_MASK) == 8'h00)
        else $error("reserved bits read non zero");

    // main scenarios
    COV_FEED: cover property (@(posedge clock) feed_r);
    COV_OFF: cover property (@(posedge clock) expiry.power_off);
    COV_RST: cover property (@(posedge clock) expiry.power_reset);
    COV_RELOAD: cover property (@(posedge clock) hit && wr.data[PER_HI:PER_LO] != period_r);
    COV_LOCKED: cover property (@(posedge clock) LOCK_DEFAULT && hit && !wr.data[ENABLE_BIT]);
endmodule
`default_nettype wire

//--- verification/tb_pmic_watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pmic_watchdog_timer import wdt_pkg::*;;
    // short base keeps the 16..128 s intervals at 10..80 cycles
    localparam int B = 10;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    reg_wr_t wr = '0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data, rd_lk;
    expiry_t expiry, exp_lk;
    logic seen = 1'b0;
    logic seen_lk = 1'b0;
    int fail_count = 0;
    int samples_checked = 0;
    int n;

    // ****************************************
    // clock, devices and helpers
    // ****************************************
    initial forever #2 clock = ~clock;

    // one copy strapped unlocked, one strapped locked
    pmic_watchdog_timer #(.BASE(B)) u_pmic_watchdog_timer (.clock(clock), .rst_n(rst_n),
        .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data), .expiry(expiry));
    pmic_watchdog_timer #(.BASE(B), .LOCK_DEFAULT(1'b1)) u_pmic_watchdog_timer_lk (
        .clock(clock), .rst_n(rst_n), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_lk),
        .expiry(exp_lk));

    // sticky flag, so a one-cycle pulse is never missed
    always @(posedge clock) seen <= seen | (expiry !== 2'b00);
    always @(posedge clock) seen_lk <= seen_lk | (exp_lk !== 2'b00);

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // callers always keep bits 7:6 at zero
    task automatic wr17(input logic [7:0] d);
        @(negedge clock);
        wr <= '{1'b1, WATCHDOG_CONTROL_ADDR, d};
        @(negedge clock);
        wr.en <= 1'b0;
    endtask

    // rd_data is registered, so look one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] el);
        @(negedge clock);
        rd_addr <= a;
        @(negedge clock);
        cmp(rd_data, e);
        cmp(rd_lk, el);
    endtask

    // bounded wait for the pulse, then judge its moment and its kind
    task automatic expire(input int lo, input int hi, input logic [1:0] e);
        n = 0;
        while (expiry === 2'b00 && n < hi + 8)
        begin
            @(negedge clock);
            n++;
        end
        cmp({7'h0, n >= lo && n <= hi}, 8'h01);
        cmp({6'h0, expiry}, {6'h0, e});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(WATCHDOG_CONTROL_ADDR, 8'h30, 8'h31);
        rd(8'h10, 8'h00, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_period;
        for (int p = 0; p < 4; p++)
        begin
            wr17({2'b00, 2'(p), p[0], 3'b110});
            expire((B << p) - 2, (B << p) + 6, p[0] ? 2'b01 : 2'b10);
        end
        $display("test period done");
    endtask

    task automatic t_feed;
        wr17(8'h06);
        seen = 1'b0;
        repeat (4)
        begin
            repeat (4) @(negedge clock);
            wr17(8'h06);
        end
        cmp({7'h0, seen}, 8'h00);
        repeat (4) @(negedge clock);
        wr17(8'h02);
        expire(1, 8, 2'b10);
        rd(WATCHDOG_CONTROL_ADDR, 8'h02, 8'h03);
        $display("test feed done");
    endtask

    task automatic t_reload;
        wr17(8'h06);
        repeat (4) @(negedge clock);
        wr17(8'h32);
        expire(8 * B - 2, 8 * B + 8, 2'b10);
        $display("test reload done");
    endtask

    // a clear of enable plus an attempt to set lock
    task automatic t_lock;
        wr17(8'h01);
        rd(WATCHDOG_CONTROL_ADDR, 8'h00, 8'h03);
        seen = 1'b0;
        seen_lk = 1'b0;
        repeat (40) @(negedge clock);
        cmp({7'h0, seen}, 8'h00);
        cmp({7'h0, seen_lk}, 8'h01);
        wr17(8'h06);
        expire(B - 2, B + 6, 2'b10);
        $display("test lock done");
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (16) @(negedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_period;
        t_feed;
        t_reload;
        t_lock;
        close_out;
    end

    // whole run needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(negedge clock);
        fail_count++;
        close_out;
    end
endmodule
`default_nettype wire
